// File: rtl/flash_ctrl_regs.svh
// offsets, field positions, reset values and timing counts of the
// flash self-programming controller; included by the key, timer and control design files.
// Function
// - core stalled while operation runs
// - operations timed from internal RC oscillator
// - row write lasts 11064 RC cycles
// - start flag bit 15 launches, self-clears
// - control selects erase blocks, memory, start
// - key register write-only, protection only
// - error flag bit 13 on bad attempts
// - error flag zero after normal completion
// - erase-select bit 6, enable bit 14
// - 0010 erase page, 0001 program row
`ifndef FLASH_CTRL_REGS_SVH
`define FLASH_CTRL_REGS_SVH

`define CTRL_OFFSET        8'h00
`define KEY_OFFSET         8'h04
`define TUNE_OFFSET        8'h08
`define IRQ_STATUS_OFFSET  8'h0C
`define IRQ_CLEAR_OFFSET   8'h10
`define IRQ_ENABLE_OFFSET  8'h14

`define CTRL_START_BIT     15
`define CTRL_ENABLE_BIT    14
`define CTRL_ERROR_BIT     13
`define CTRL_ERASE_BIT     6
`define CTRL_OP_LSB        0
`define CTRL_RESET         16'h0000
`define TUNE_RESET         6'h00
`define IRQ_RESET          2'h0
`define IRQ_DONE_BIT       0
`define IRQ_ERROR_BIT      1

`define OP_PAGE_ERASE      4'h2
`define OP_ROW_PROGRAM     4'h1
`define KEY_FIRST          8'h55
`define KEY_SECOND         8'hAA

// rc oscillator: 7.37 MHz against 40 MHz pclk, 16-bit phase step
`define RC_FREQ_KHZ        7370
`define PCLK_FREQ_KHZ      40000
`define RC_BASE_INC        ((`RC_FREQ_KHZ * 65536 + `PCLK_FREQ_KHZ / 2) / \
                            `PCLK_FREQ_KHZ)
// each tune step moves the rate by 0.375 percent
`define TUNE_STEP_MUL      3
`define TUNE_STEP_DIV      800
// 11064 rc cycles for both operations
`define ROW_WRITE_RC_CYCLES  16'h2B38
`define PAGE_ERASE_RC_CYCLES 16'h2B38

`endif

// File: rtl/flash_ctrl_pkg.sv
// types shared by the flash self-programming controller modules.
// assumes flash_ctrl_regs.svh supplies the numeric constants.
package flash_ctrl_pkg;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_GOT_FIRST,
		KEY_OPEN
	} key_state_t;

	typedef enum logic {
		CTL_IDLE,
		CTL_RUN
	} ctl_state_t;

	typedef struct packed {
		key_state_t state;
	} key_regs_t;

	typedef struct packed {
		logic [15:0] phase;
		logic [15:0] count;
		logic        busy;
		logic        done;
	} tmr_regs_t;

	typedef struct packed {
		ctl_state_t  state;
		logic        enable;
		logic        error;
		logic        erase;
		logic [3:0]  op;
		logic [5:0]  tune;
		logic [1:0]  irq_status;
		logic [1:0]  irq_enable;
		logic        start_pulse;
		logic [31:0] rdata;
	} ctl_regs_t;

endpackage

// File: rtl/flash_seq_if.sv
// carries key-unlock and operation-timer signals inside the controller.
// assumes all endpoints run on pclk.
`timescale 1ns/1ps
interface flash_seq_if;
	logic        any_wr;
	logic        key_wr;
	logic [7:0]  key_data;
	logic        unlocked;
	logic        tmr_start;
	logic        tmr_abort;
	logic [15:0] tmr_limit;
	logic [5:0]  tmr_tune;
	logic        tmr_done;

	modport ctl (
		output any_wr, key_wr, key_data, tmr_start, tmr_abort,
		output tmr_limit, tmr_tune,
		input  unlocked, tmr_done
	);
	modport key (
		input  any_wr, key_wr, key_data,
		output unlocked
	);
	modport tmr (
		input  tmr_start, tmr_abort, tmr_limit, tmr_tune,
		output tmr_done
	);
endinterface

// File: rtl/flash_unlock_key.sv
// two-write unlock detector for the write-only key register.
// assumes one any_wr pulse per accepted bus write, key_wr alongside.
`timescale 1ns/1ps
`include "flash_ctrl_regs.svh"
module flash_unlock_key (
	input  wire logic pclk,
	input  wire logic presetn,
	flash_seq_if.key  seq
);
	flash_ctrl_pkg::key_regs_t r_reg;
	flash_ctrl_pkg::key_regs_t r_next;

	always_comb begin
		r_next = r_reg;
		if (seq.any_wr) begin
			// any other write or wrong value cancels the unlock
			r_next.state = flash_ctrl_pkg::KEY_IDLE;
			if (seq.key_wr && seq.key_data == `KEY_FIRST) begin
				r_next.state = flash_ctrl_pkg::KEY_GOT_FIRST;
			end
			if (seq.key_wr && seq.key_data == `KEY_SECOND &&
			    r_reg.state == flash_ctrl_pkg::KEY_GOT_FIRST) begin
				r_next.state = flash_ctrl_pkg::KEY_OPEN;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg.state <= flash_ctrl_pkg::KEY_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	// open only for the single write that follows the second key
	assign seq.unlocked = (r_reg.state == flash_ctrl_pkg::KEY_OPEN);
endmodule

// File: rtl/flash_op_timer.sv
// self-timed operation counter clocked by a model of the internal
// rc oscillator: a tuned phase accumulator gives one tick per rc cycle.
// assumes start and abort are one-cycle pulses.
`timescale 1ns/1ps
`include "flash_ctrl_regs.svh"
module flash_op_timer (
	input  wire logic pclk,
	input  wire logic presetn,
	flash_seq_if.tmr  seq
);
	flash_ctrl_pkg::tmr_regs_t r_reg;
	flash_ctrl_pkg::tmr_regs_t r_next;

	// phase step for the tuned oscillator rate
	function automatic logic [15:0] rc_increment(input logic [5:0] oscillator_tune_field);
		int v;
		v = `RC_BASE_INC +
		    (`RC_BASE_INC * int'($signed(oscillator_tune_field)) * `TUNE_STEP_MUL) /
		    `TUNE_STEP_DIV;
		return v[15:0];
	endfunction

	logic [16:0] sum;

	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		sum = {1'b0, r_reg.phase} + {1'b0, rc_increment(seq.tmr_tune)};
		if (r_reg.busy) begin
			r_next.phase = sum[15:0];
			if (sum[16]) begin
				r_next.count = r_reg.count + 16'h0001;
				if (r_next.count == seq.tmr_limit) begin
					r_next.busy = 1'b0;
					r_next.done = 1'b1;
				end
			end
		end
		if (seq.tmr_abort) begin
			r_next.busy = 1'b0;
			r_next.done = 1'b0;
		end
		if (seq.tmr_start) begin
			r_next.phase = 16'h0000;
			r_next.count = 16'h0000;
			r_next.busy  = 1'b1;
			r_next.done  = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign seq.tmr_done = r_reg.done;
endmodule

// File: rtl/flash_self_program_control.sv
// flash self-programming controller: apb register file, unlock-checked
// start of page erase or row program, core stall and completion events.
// assumes an apb master on pclk and a flash array that follows the
// array_* outputs; op_abort is synchronous to pclk.
`timescale 1ns/1ps
`include "flash_ctrl_regs.svh"
module flash_self_program_control #(
	parameter logic [15:0] ROW_WRITE_CYCLES  = `ROW_WRITE_RC_CYCLES,
	parameter logic [15:0] PAGE_ERASE_CYCLES = `PAGE_ERASE_RC_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        op_abort,
	output logic             cpu_stall,
	output logic             array_op_active,
	output logic             array_start,
	output logic             array_erase,
	output logic [3:0]       array_op_select,
	output logic             irq
);
	flash_ctrl_pkg::ctl_regs_t r_reg;
	flash_ctrl_pkg::ctl_regs_t r_next;

	flash_seq_if seq ();

	flash_unlock_key u_key (
		.pclk    (pclk),
		.presetn (presetn),
		.seq     (seq.key)
	);

	flash_op_timer u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.seq     (seq.tmr)
	);

	// address decode shared by write accept and error answer
	function automatic logic addr_hit(input logic [7:0] a);
		case (a)
			`CTRL_OFFSET,
			`KEY_OFFSET,
			`TUNE_OFFSET,
			`IRQ_STATUS_OFFSET,
			`IRQ_CLEAR_OFFSET,
			`IRQ_ENABLE_OFFSET: addr_hit = 1'b1;
			default:            addr_hit = 1'b0;
		endcase
	endfunction

	// only the two documented codes are legal in this variant
	function automatic logic op_legal(input logic erase,
	                                  input logic [3:0] op);
		op_legal = erase ? (op == `OP_PAGE_ERASE)
		                 : (op == `OP_ROW_PROGRAM);
	endfunction

	logic        busy;
	logic        wr_acc;
	logic        rd_setup;
	logic        ctrl_wr;
	logic        start_try;
	logic        start_ok;
	logic        ev_done;
	logic        ev_error;
	logic [1:0]  events;
	logic [15:0] ctrl_view;

	assign busy     = (r_reg.state == flash_ctrl_pkg::CTL_RUN);
	assign wr_acc   = psel && penable && pwrite && addr_hit(paddr);
	assign rd_setup = psel && !penable && !pwrite;
	assign ctrl_wr  = wr_acc && (paddr == `CTRL_OFFSET);

	// every set attempt of the start flag while idle is judged
	assign start_try = ctrl_wr && !busy && pwdata[`CTRL_START_BIT];
	assign start_ok  = start_try && seq.unlocked &&
	                   pwdata[`CTRL_ENABLE_BIT] &&
	                   op_legal(pwdata[`CTRL_ERASE_BIT],
	                            pwdata[`CTRL_OP_LSB +: 4]);

	assign ev_done  = busy && seq.tmr_done && !op_abort;
	assign ev_error = (start_try && !start_ok) || (busy && op_abort);
	assign events   = {ev_error, ev_done};

	// unimplemented control bits read as zero
	always_comb begin
		ctrl_view = `CTRL_RESET;
		ctrl_view[`CTRL_START_BIT]     = busy;
		ctrl_view[`CTRL_ENABLE_BIT]    = r_reg.enable;
		ctrl_view[`CTRL_ERROR_BIT]     = r_reg.error;
		ctrl_view[`CTRL_ERASE_BIT]     = r_reg.erase;
		ctrl_view[`CTRL_OP_LSB +: 4]   = r_reg.op;
	end

	// interface drive toward key checker and timer
	assign seq.any_wr    = wr_acc;
	assign seq.key_wr    = wr_acc && (paddr == `KEY_OFFSET);
	assign seq.key_data  = pwdata[7:0];
	assign seq.tmr_start = start_ok;
	assign seq.tmr_abort = busy && op_abort;
	// limit follows the frozen erase bit of the running operation,
	// not the bus, which may change while the core is stalled
	assign seq.tmr_limit = r_reg.erase ? PAGE_ERASE_CYCLES
	                                   : ROW_WRITE_CYCLES;
	assign seq.tmr_tune  = r_reg.tune;

	always_comb begin
		r_next = r_reg;
		r_next.start_pulse = 1'b0;

		case (r_reg.state)
			flash_ctrl_pkg::CTL_IDLE: begin
				if (ctrl_wr) begin
					// fields are frozen while an operation runs
					r_next.enable = pwdata[`CTRL_ENABLE_BIT];
					r_next.erase  = pwdata[`CTRL_ERASE_BIT];
					r_next.op     = pwdata[`CTRL_OP_LSB +: 4];
					// software may clear the error flag, never set it
					r_next.error  = r_reg.error &&
					                pwdata[`CTRL_ERROR_BIT];
				end
				if (start_ok) begin
					r_next.state       = flash_ctrl_pkg::CTL_RUN;
					r_next.error       = 1'b0;
					r_next.start_pulse = 1'b1;
				end else if (start_try) begin
					r_next.error = 1'b1;
				end
			end
			flash_ctrl_pkg::CTL_RUN: begin
				if (op_abort) begin
					// premature termination
					r_next.state = flash_ctrl_pkg::CTL_IDLE;
					r_next.error = 1'b1;
				end else if (seq.tmr_done) begin
					// start flag clears itself on completion
					r_next.state = flash_ctrl_pkg::CTL_IDLE;
				end
			end
			default: begin
				r_next.state = flash_ctrl_pkg::CTL_IDLE;
			end
		endcase

		if (wr_acc && !busy && paddr == `TUNE_OFFSET) begin
			r_next.tune = pwdata[5:0];
		end
		if (wr_acc && paddr == `IRQ_ENABLE_OFFSET) begin
			r_next.irq_enable = pwdata[1:0];
		end
		// a new event wins over a clear in the same cycle
		r_next.irq_status = r_reg.irq_status;
		if (wr_acc && paddr == `IRQ_CLEAR_OFFSET) begin
			r_next.irq_status = r_reg.irq_status & ~pwdata[1:0];
		end
		r_next.irq_status = r_next.irq_status | events;

		// read data captured in the setup phase
		if (rd_setup) begin
			case (paddr)
				`CTRL_OFFSET:       r_next.rdata = {16'h0000, ctrl_view};
				`TUNE_OFFSET:       r_next.rdata = {26'h000_0000, r_reg.tune};
				`IRQ_STATUS_OFFSET: r_next.rdata = {30'h0000_0000,
				                                    r_reg.irq_status};
				`IRQ_ENABLE_OFFSET: r_next.rdata = {30'h0000_0000,
				                                    r_reg.irq_enable};
				// key and clear registers are write-only
				default:            r_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg.state       <= flash_ctrl_pkg::CTL_IDLE;
			r_reg.enable      <= 1'b0;
			r_reg.error       <= 1'b0;
			r_reg.erase       <= 1'b0;
			r_reg.op          <= 4'h0;
			r_reg.tune        <= `TUNE_RESET;
			r_reg.irq_status  <= `IRQ_RESET;
			r_reg.irq_enable  <= `IRQ_RESET;
			r_reg.start_pulse <= 1'b0;
			r_reg.rdata       <= 32'h0000_0000;
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata  = r_reg.rdata;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_hit(paddr);

	// core held off for the whole self-timed operation
	assign cpu_stall       = busy;
	assign array_op_active = busy;
	assign array_start     = r_reg.start_pulse;
	assign array_erase     = r_reg.erase;
	assign array_op_select = r_reg.op;
	assign irq = |(r_reg.irq_status & r_reg.irq_enable);
endmodule

// File: testbench/flash_ctrl_monitor.sv
// port checker for the flash self-programming controller
// assumes binding to flash_self_program_control, single pclk domain
`timescale 1ns/1ps
module flash_ctrl_monitor #(
	parameter logic [15:0] ROW_WRITE_CYCLES  = 16'h0004,
	parameter logic [15:0] PAGE_ERASE_CYCLES = 16'h0004
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        op_abort,
	input wire logic        cpu_stall,
	input wire logic        array_op_active,
	input wire logic        array_start,
	input wire logic        array_erase,
	input wire logic [3:0]  array_op_select,
	input wire logic        irq
);
	localparam logic [15:0] HI = (ROW_WRITE_CYCLES > PAGE_ERASE_CYCLES) ?
		ROW_WRITE_CYCLES : PAGE_ERASE_CYCLES;
	localparam logic [15:0] LO = (ROW_WRITE_CYCLES < PAGE_ERASE_CYCLES) ?
		ROW_WRITE_CYCLES : PAGE_ERASE_CYCLES;
	logic [19:0] stall_cnt;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_cnt <= 20'h0_0000;
		end else begin
			stall_cnt <= cpu_stall ? stall_cnt + 20'h0_0001 : 20'h0_0000;
		end
	end
	sequence s_read_at(logic [7:0] a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	a_stall_mirror: assert property (cpu_stall == array_op_active)
		else $error("stall and array activity differ");
	a_start_at_rise: assert property (array_start == $rose(cpu_stall))
		else $error("start pulse not at stall rise");
	a_start_readback: assert property (s_read_at(8'h00) |->
		prdata[15] == $past(cpu_stall)) else $error("start bit wrong");
	a_ctrl_unused: assert property (s_read_at(8'h00) |->
		prdata[31:16] == 16'h0000 && prdata[12:7] == 6'h00 &&
		prdata[5:4] == 2'h0) else $error("unused control bits set");
	a_key_hidden: assert property (s_read_at(8'h04) |->
		prdata == 32'h0000_0000) else $error("key readable");
	a_op_select: assert property (array_start |-> (array_erase ?
		array_op_select == 4'h2 : array_op_select == 4'h1))
		else $error("illegal operation launched");
	a_stall_max: assert property (cpu_stall |->
		stall_cnt < HI * 7 + 8) else $error("operation too long");
	a_stall_min: assert property ($fell(cpu_stall) && !$past(op_abort) |->
		stall_cnt >= (LO - 1) * 4) else $error("operation too short");
endmodule

bind flash_self_program_control flash_ctrl_monitor #(
	.ROW_WRITE_CYCLES(ROW_WRITE_CYCLES),
	.PAGE_ERASE_CYCLES(PAGE_ERASE_CYCLES)
) mon_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .op_abort(op_abort),
	.cpu_stall(cpu_stall), .array_op_active(array_op_active),
	.array_start(array_start), .array_erase(array_erase),
	.array_op_select(array_op_select), .irq(irq)
);

// File: testbench/flash_array_model.sv
// behavioural flash array: counts the erase and program cycles it runs
// assumes the controller's array_* outputs on pclk
`timescale 1ns/1ps
module flash_array_model (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       array_start,
	input wire logic       array_erase,
	input wire logic [3:0] array_op_select,
	output int             erase_count,
	output int             program_count
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_count <= 0;
			program_count <= 0;
		end else if (array_start && array_erase && array_op_select == 4'h2) begin
			erase_count <= erase_count + 1;
		end else if (array_start && array_op_select == 4'h1) begin
			program_count <= program_count + 1;
		end
	end
endmodule

// File: testbench/flash_self_program_control_bench.sv
// self-checking bench: apb register access, unlock and operation runs
// assumes the controller, its monitor and the flash array model
`timescale 1ns/1ps
module flash_self_program_control_bench;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        op_abort;
	logic        cpu_stall;
	logic        array_start;
	logic        array_erase;
	logic [3:0]  array_op_select;
	logic        irq;
	logic        err_seen;
	logic [31:0] rd;
	int          erase_count;
	int          program_count;
	int          num_errors;
	int          checks;

	flash_self_program_control #(.ROW_WRITE_CYCLES(16'h0004),
		.PAGE_ERASE_CYCLES(16'h0004)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .op_abort(op_abort),
		.cpu_stall(cpu_stall), .array_op_active(), .array_start(array_start),
		.array_erase(array_erase), .array_op_select(array_op_select),
		.irq(irq));
	flash_array_model model_u (.pclk(pclk), .presetn(presetn),
		.array_start(array_start), .array_erase(array_erase),
		.array_op_select(array_op_select), .erase_count(erase_count),
		.program_count(program_count));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	// keys, optional stray write, start; then completion and status
	task automatic op(input logic [15:0] c, input logic [7:0] k1,
		input logic [7:0] k2, input logic mid, input logic good,
		input logic brk);
		logic [15:0] e;
		int n;
		e = (c & 16'h404F) | (good ? 16'h0000 : 16'h2000);
		apb(1'b1, 8'h04, {24'h00_0000, k1});
		if (mid) apb(1'b1, 8'h08, 32'h0000_0000);
		apb(1'b1, 8'h04, {24'h00_0000, k2});
		apb(1'b1, 8'h00, {16'h0000, c});
		check("stall", cpu_stall, good);
		if (good) begin
			check("erase", array_erase, c[6]);
			apb(1'b0, 8'h00, 32'h0000_0000);
			check("start", rd[15], 1'b1);
			if (brk) begin
				@(posedge pclk);
				op_abort <= 1'b1;
				@(posedge pclk);
				op_abort <= 1'b0;
				e = e | 16'h2000;
			end
			n = 0;
			while (cpu_stall === 1'b1 && n < 400) begin
				@(posedge pclk);
				#1;
				n++;
			end
			check("stall end", cpu_stall, 1'b0);
		end
		apb(1'b0, 8'h00, 32'h0000_0000);
		check("ctrl", rd, {16'h0000, e});
		apb(1'b0, 8'h0C, 32'h0000_0000);
		check("status", rd, {30'h0000_0000, e[13], !e[13]});
		check("irq", irq, 1'b1);
		apb(1'b1, 8'h10, 32'h0000_0003);
		check("irq clear", irq, 1'b0);
	endtask

	task automatic close_out();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		num_errors++;
		close_out();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		op_abort = 1'b0;
		num_errors = 0;
		checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0000_0000);
		check("ctrl reset", rd, 32'h0000_0000);
		apb(1'b0, 8'h04, 32'h0000_0000);
		check("key read", rd, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		check("unmapped", err_seen, 1'b1);
		apb(1'b1, 8'h14, 32'h0000_0003);
		op(16'hC042, 8'h55, 8'hAA, 1'b0, 1'b1, 1'b0);
		op(16'hC001, 8'h55, 8'hAA, 1'b0, 1'b1, 1'b0);
		op(16'hC001, 8'hAA, 8'h55, 1'b0, 1'b0, 1'b0);
		op(16'hC001, 8'h55, 8'hAA, 1'b1, 1'b0, 1'b0);
		op(16'h8001, 8'h55, 8'hAA, 1'b0, 1'b0, 1'b0);
		op(16'hC041, 8'h55, 8'hAA, 1'b0, 1'b0, 1'b0);
		op(16'hC002, 8'h55, 8'hAA, 1'b0, 1'b0, 1'b0);
		op(16'hC001, 8'h55, 8'hAA, 1'b0, 1'b1, 1'b1);
		op(16'hC001, 8'h55, 8'hAA, 1'b0, 1'b1, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_C001);
		apb(1'b0, 8'h00, 32'h0000_0000);
		check("no unlock", rd, 32'h0000_6001);
		apb(1'b1, 8'h00, 32'h0000_4001);
		apb(1'b0, 8'h00, 32'h0000_0000);
		check("error clear", rd, 32'h0000_4001);
		apb(1'b1, 8'h10, 32'h0000_0003);
		apb(1'b1, 8'h08, 32'h0000_003F);
		apb(1'b0, 8'h08, 32'h0000_0000);
		check("tune", rd, 32'h0000_003F);
		apb(1'b0, 8'h14, 32'h0000_0000);
		check("irq enable", rd, 32'h0000_0003);
		op(16'hC001, 8'h55, 8'hAA, 1'b0, 1'b1, 1'b0);
		check("erases", erase_count, 32'h0000_0001);
		check("programs", program_count, 32'h0000_0004);
		close_out();
	end
endmodule
